// ---- core/sdcm_cfg_bank.sv ----
// Config and mask register bank of the octal switch with LED, filter and watchdog logic
`timescale 1ns/1ps
// What this block does
// RL1: Current-limit LED mask hides limiting on internal fault LEDs; chained mode always hides it.
// RL2: Latch enable makes the five per-channel diagnostic flags sticky, else real time.
// RL3: Internal fault LED on-time ignores latching; stays on while the fault stands plus the stretch after it clears.
// RL4: Long blanking select picks 8ms blanking instead of 4ms.
// RL5: Filter enable off gives unblanked open-wire and short bits, 50us filter only.
// RL6: Internal fault LEDs always use blanked diagnostics.
// RL7: Stretch field gives minimum fault LED on-time of 0, 1, 2 or 3 seconds.
// RL8: Chained mode forces a two-second stretch.
// RL9: Status LEDs follow their set register when manual and not chained.
// RL10: Fault LEDs follow their set register when manual and not chained, else internal detection.
// RL11: Chained mode drives fault LEDs from overload only.
// RL12: Watchdog code sets serial and update-input timeouts from the table.
// RL13: Chained mode uses 1.2s timeouts, each enabled by its address strap.
// RL14: Open-wire current field passes to the pull-up source select.
// RL15: Short-to-supply threshold field passes to the detector threshold select.
// RL16: Restart select or chained mode picks the high supply restart threshold.
// RL17: Comm mask keeps watchdog timeouts off the fault output, still reported.
// RL18: Chained mode keeps watchdogs off fault; comm bit shown only with CRC strap.
// RL19: Supply mask keeps supply errors off the fault output, still reported.
// RL20: Chained mode keeps supply errors off fault; serial bit only with CRC strap.
// RL21: Supply-good mask or chained mode drops not-good and warning from supply error.
// RL22: Short and open-wire masks keep those faults off fault output; chained disables them.
// RL23: Current-limit mask keeps overcurrent off fault output, still reported.
// RL24: Overload mask keeps overload off fault output, still reported.
// RL25: Fault output is active while any unmasked fault source is active; comm and supply errors count only when not chained.
module sdcm_cfg_bank #(
  parameter logic [17:0] BLANK_SHORT_CYCLES = 18'(sdcm_pkg::BLANK_SHORT_CYC),
  parameter logic [17:0] BLANK_LONG_CYCLES  = 18'(sdcm_pkg::BLANK_LONG_CYC),
  parameter logic [26:0] STRETCH_CYCLES     = 27'(sdcm_pkg::STRETCH_CYC),
  parameter logic [24:0] WD_SHORT_CYCLES    = 25'(sdcm_pkg::WD_SHORT_CYC),
  parameter logic [24:0] WD_MID_CYCLES      = 25'(sdcm_pkg::WD_MID_CYC),
  parameter logic [24:0] WD_LONG_CYCLES     = 25'(sdcm_pkg::WD_LONG_CYC)
) (
  // Core clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Serial link register port
  input  wire logic                      link_clk,
  input  wire logic                      link_wr,
  input  wire logic [3:0]                link_addr,
  input  wire logic [7:0]                link_wdata,
  output logic                           link_busy,
  output logic [7:0]                     link_rdata,
  // Straps and pins
  input  wire logic                      chain_pin,
  input  wire logic                      crc_strap,
  input  wire logic                      address0_watchdog_strap,
  input  wire logic                      address1_update_watchdog_strap,
  input  wire logic                      update_pin,
  // Diagnostics from the switch core
  input  wire sdcm_pkg::sdcm_diag_type   diag_raw,
  input  wire sdcm_pkg::sdcm_det_en_type det_en,
  input  wire logic [4:0]                flag_clear,
  input  wire logic                      comm_clear,
  input  wire logic                      supply_not_good_flag,
  input  wire logic                      supply_warning_flag,
  input  wire logic                      supply_fail,
  // LED sources
  input  wire logic [7:0]                status_auto,
  input  wire logic [7:0]                status_led_set_register,
  input  wire logic [7:0]                fault_led_set_register,
  // Results
  output sdcm_pkg::sdcm_diag_type        diag_flags,
  output sdcm_pkg::sdcm_out_type         outs
);
  import sdcm_pkg::*;

  function automatic logic [7:0] reg_read(sdcm_regs_type r, logic [3:0] a);
    case (a)
      LED_CFG_ADDR: reg_read = r.led_cfg;
      WD_CFG_ADDR:  reg_read = r.wd_cfg;
      MASK_ADDR:    reg_read = r.mask;
      default:      reg_read = 8'h00;
    endcase
  endfunction : reg_read

  function automatic logic [WD_W-1:0] wd_tmo(logic [1:0] code, logic upd);
    case (code)
      2'b00:   wd_tmo = upd ? WD_MID_CYCLES : '0;
      2'b01:   wd_tmo = WD_SHORT_CYCLES;
      2'b10:   wd_tmo = WD_MID_CYCLES;
      default: wd_tmo = WD_LONG_CYCLES;
    endcase
  endfunction : wd_tmo

  // Link domain: one write in flight, acked by the core's publish toggle
  sdcm_link_req_type req_ff, nxt_req;
  sdcm_regs_type     shadow_ff, nxt_shadow;
  logic [7:0]        rdata_ff, nxt_rdata;
  logic              ack_s1_ff, ack_s2_ff, ack_s3_ff;

  sdcm_regs_type     regs_ff, nxt_regs;
  logic              pub_ff, nxt_pub;

  assign link_busy  = req_ff.tgl != ack_s2_ff;
  assign link_rdata = rdata_ff;

  always_comb begin
    nxt_req = req_ff;
    if (link_wr && !link_busy) begin
      nxt_req.tgl  = ~req_ff.tgl;
      nxt_req.addr = link_addr;
      nxt_req.data = link_wdata;
    end
    // Core registers are steady for a whole toggle round trip
    nxt_shadow = (ack_s2_ff != ack_s3_ff) ? regs_ff : shadow_ff;
    nxt_rdata  = reg_read(shadow_ff, link_addr);
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ff    <= '0;
      shadow_ff <= '{LED_CFG_RST, WD_CFG_RST, MASK_RST};
      rdata_ff  <= 8'h00;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
    end else begin
      req_ff    <= nxt_req;
      shadow_ff <= nxt_shadow;
      rdata_ff  <= nxt_rdata;
      ack_s1_ff <= pub_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
    end
  end

  // Core domain: pin and request synchronisers
  logic [5:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic       chain_q, wr_pulse, upd_edge;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_ff <= 6'h00;
      pin_s2_ff <= 6'h00;
      pin_s3_ff <= 6'h00;
    end else begin
      pin_s1_ff <= {req_ff.tgl, update_pin, address1_update_watchdog_strap,
                    address0_watchdog_strap, crc_strap, chain_pin};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  assign chain_q  = pin_s2_ff[0];
  assign wr_pulse = pin_s2_ff[5] ^ pin_s3_ff[5];
  assign upd_edge = pin_s2_ff[4] ^ pin_s3_ff[4];

  always_comb begin
    nxt_regs = regs_ff;
    if (wr_pulse) begin
      case (req_ff.addr)
        LED_CFG_ADDR: nxt_regs.led_cfg = req_ff.data;
        WD_CFG_ADDR:  nxt_regs.wd_cfg  = req_ff.data;
        MASK_ADDR:    nxt_regs.mask    = req_ff.data;
        default:      nxt_regs = regs_ff;
      endcase
    end
    // Unmapped writes are still acked so the link never hangs
    nxt_pub = pub_ff ^ wr_pulse;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs_ff <= '{LED_CFG_RST, WD_CFG_RST, MASK_RST};
      pub_ff  <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
      pub_ff  <= nxt_pub;
    end
  end

  // Diagnostic filters, flags and fault LEDs
  logic [2:0][7:0][BLANK_W-1:0] fcnt_ff, nxt_fcnt;
  logic [7:0][STR_W-1:0]        str_ff, nxt_str;
  sdcm_diag_type                flags_ff, nxt_flags, cur;
  logic [BLANK_W-1:0]           blank_thr;
  logic [STR_W-1:0]             str_len;
  logic [7:0]                   led_q, src;
  logic                         cond, latch;

  always_comb begin
    latch     = regs_ff.led_cfg[B_LATCH_EN];
    blank_thr = regs_ff.led_cfg[B_LONG_BLANK] ? BLANK_LONG_CYCLES
                                              : BLANK_SHORT_CYCLES; // see RL4
    cur       = '0;
    led_q     = 8'h00;
    cond      = 1'b0;
    cur[C_OVL]  = diag_raw[C_OVL];
    cur[C_CLIM] = diag_raw[C_CLIM];
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 8; i++) begin
        cond = diag_raw[c+2][i] & det_en[c][i] & ~chain_q; // see RL22
        if (!cond) begin
          nxt_fcnt[c][i] = '0;
        end else if (fcnt_ff[c][i] >= blank_thr) begin
          nxt_fcnt[c][i] = fcnt_ff[c][i];
        end else begin
          nxt_fcnt[c][i] = fcnt_ff[c][i] + 1'b1;
        end
        cur[c+2][i] = cond && (regs_ff.led_cfg[B_FILT_EN] ? fcnt_ff[c][i] >= blank_thr
                                                          : fcnt_ff[c][i] >= FILT_CNT); // see RL5
        led_q[i] = led_q[i] | (cond && fcnt_ff[c][i] >= blank_thr); // see RL6
      end
    end
    for (int c = 0; c < 5; c++) begin
      // A new event wins over a clear in the same cycle
      nxt_flags[c] = latch ? cur[c] | (flags_ff[c] & ~{8{flag_clear[c]}}) : cur[c]; // see RL2
    end
    if (chain_q) begin
      src = cur[C_OVL]; // see RL11
    end else begin
      src = cur[C_OVL] | led_q
          | (cur[C_CLIM] & ~{8{regs_ff.led_cfg[B_LED_CLIM_MASK]}}); // see RL1
    end
    str_len = STR_W'((chain_q ? 2'b10 : regs_ff.led_cfg[B_STRETCH_LO +: 2])
                     * STRETCH_CYCLES); // see RL7 RL8
    for (int i = 0; i < 8; i++) begin
      // Stretch reloads while the fault stands, so latching has no effect here
      if (src[i]) begin
        nxt_str[i] = str_len; // see RL3
      end else if (str_ff[i] != '0) begin
        nxt_str[i] = str_ff[i] - 1'b1;
      end else begin
        nxt_str[i] = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt_ff  <= '0;
      str_ff   <= '0;
      flags_ff <= '0;
    end else begin
      fcnt_ff  <= nxt_fcnt;
      str_ff   <= nxt_str;
      flags_ff <= nxt_flags;
    end
  end

  assign diag_flags = flags_ff;

  // Watchdogs: 0 = serial link, 1 = update input
  logic [1:0][WD_W-1:0] wcnt_ff, nxt_wcnt;
  logic [1:0][WD_W-1:0] tmo;
  logic [1:0]           wd_en, act, evt;
  logic [1:0]           wd_code;
  logic                 comm_ff, nxt_comm, sup_err;
  sdcm_out_type         outs_ff, nxt_outs;

  always_comb begin
    wd_code  = chain_q ? 2'b11 : regs_ff.wd_cfg[B_WD_LO +: 2]; // see RL13
    wd_en[0] = chain_q ? pin_s2_ff[2] : (regs_ff.wd_cfg[B_WD_LO +: 2] != 2'b00);
    wd_en[1] = chain_q ? pin_s2_ff[3] : regs_ff.wd_cfg[B_UPD_WD_EN]; // see RL13
    act      = {upd_edge, wr_pulse};
    for (int k = 0; k < 2; k++) begin
      tmo[k] = wd_tmo(wd_code, k[0]); // see RL12
      evt[k] = wd_en[k] && !act[k] && (wcnt_ff[k] >= tmo[k] - 1'b1);
      nxt_wcnt[k] = (!wd_en[k] || act[k] || evt[k]) ? '0 : wcnt_ff[k] + 1'b1;
    end
    // Timeout wins over a clear in the same cycle
    nxt_comm = (|evt) | (comm_ff & ~comm_clear);
    sup_err  = supply_fail | (~regs_ff.mask[B_GOOD_M] & ~chain_q
                              & (supply_not_good_flag | supply_warning_flag)); // see RL21
    nxt_outs.fault_active =
        |(flags_ff[C_OVL]   & ~{8{regs_ff.mask[B_OVL_M]}})    // see RL24
      | |(flags_ff[C_CLIM]  & ~{8{regs_ff.mask[B_CLIM_M]}})   // see RL23
      | |(flags_ff[C_OWOFF] & ~{8{regs_ff.mask[B_OWOFF_M]}})  // see RL22
      | |(flags_ff[C_OWON]  & ~{8{regs_ff.mask[B_OWON_M]}})
      | |(flags_ff[C_SHORT] & ~{8{regs_ff.mask[B_SHORT_M]}})
      | (comm_ff & ~regs_ff.mask[B_COMM_M] & ~chain_q)        // see RL17 RL18
      | (sup_err & ~regs_ff.mask[B_SUP_M] & ~chain_q);        // see RL19 RL20 RL25
    nxt_outs.global_irq_flag         = (|flags_ff) | comm_ff | sup_err;
    nxt_outs.comm_error_irq_bit      = comm_ff & (~chain_q | pin_s2_ff[1]); // see RL18
    nxt_outs.supply_error_irq_bit    = sup_err & ~chain_q;
    nxt_outs.serial_supply_error_bit = sup_err & chain_q & pin_s2_ff[1]; // see RL20
    nxt_outs.restart_high_thr        = regs_ff.wd_cfg[B_RESTART] | chain_q; // see RL16
    nxt_outs.open_wire_current_sel   = regs_ff.wd_cfg[B_OWCUR_LO +: 2]; // see RL14
    nxt_outs.short_supply_threshold_sel = regs_ff.wd_cfg[B_SHTHR_LO +: 2]; // see RL15
    if (!chain_q && regs_ff.led_cfg[B_FAULT_LED_MAN]) begin
      nxt_outs.fault_led = fault_led_set_register; // see RL10
    end else begin
      nxt_outs.fault_led = src | led_stretch_on(str_ff);
    end
    if (!chain_q && regs_ff.led_cfg[B_STATUS_LED_MAN]) begin
      nxt_outs.status_led = status_led_set_register; // see RL9
    end else begin
      nxt_outs.status_led = status_auto;
    end
  end

  function automatic logic [7:0] led_stretch_on(logic [7:0][STR_W-1:0] s);
    for (int i = 0; i < 8; i++) begin
      led_stretch_on[i] = s[i] != '0;
    end
  endfunction : led_stretch_on

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wcnt_ff <= '0;
      comm_ff <= 1'b0;
      outs_ff <= '0;
    end else begin
      wcnt_ff <= nxt_wcnt;
      comm_ff <= nxt_comm;
      outs_ff <= nxt_outs;
    end
  end

  assign outs = outs_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fault_led_manual: assert property (
    (!chain_q && regs_ff.led_cfg[B_FAULT_LED_MAN])
      |=> outs_ff.fault_led == $past(fault_led_set_register)) // see RL10
    else $error("fault LEDs do not follow set register");
  a_status_led_auto: assert property (
    chain_q |=> outs_ff.status_led == $past(status_auto)) // see RL9
    else $error("status LEDs not autonomous in chained mode");
  a_restart_thr_sel: assert property (
    chain_q |=> outs_ff.restart_high_thr) // see RL16
    else $error("chained mode must use high restart threshold");
  a_fault_all_masked: assert property (
    (regs_ff.mask == 8'hFF && !sup_err) ##1 (regs_ff.mask == 8'hFF)
      |=> !outs_ff.fault_active) // see RL25
    else $error("fault output active with all sources masked");
  a_chain_no_supply: assert property (
    (chain_q && flags_ff == '0) |=> !outs_ff.fault_active) // see RL20
    else $error("supply or watchdog reached fault in chained mode");
  a_latch_holds_flag: assert property (
    (latch && !wr_pulse && flag_clear == 5'h00)
      |=> (($past(flags_ff) & ~flags_ff) == '0)) // see RL2
    else $error("latched flag dropped without clear");
  a_realtime_flag: assert property (
    (!latch && !wr_pulse) |=> flags_ff[C_OVL] == $past(diag_raw[C_OVL])) // see RL2
    else $error("unlatched overload flag not real time");
  a_unfiltered_owoff: assert property (
    (!regs_ff.led_cfg[B_FILT_EN] && !wr_pulse && !chain_q && diag_raw[C_OWOFF][0]
     && det_en[0][0] && fcnt_ff[0][0] >= FILT_CNT) |=> flags_ff[C_OWOFF][0]) // see RL5
    else $error("open-wire bit missing after short filter");
  a_stretch_one_s: assert property (
    (!chain_q && regs_ff.led_cfg[B_STRETCH_LO +: 2] == 2'b01 && src[0])
      |=> str_ff[0] == STRETCH_CYCLES) // see RL7
    else $error("one second stretch not loaded");
  a_chain_stretch: assert property (
    (chain_q && src[0]) |=> str_ff[0] == STR_W'(2 * STRETCH_CYCLES)) // see RL8
    else $error("chained stretch not two seconds");
  a_wd_sets_comm: assert property (
    (wd_en[0] && !wr_pulse && wcnt_ff[0] == tmo[0] - 1'b1)
      |=> comm_ff && wcnt_ff[0] == '0) // see RL12
    else $error("serial watchdog timeout not reported");

  c_fault_rises: cover property ($rose(outs_ff.fault_active));
  c_led_stretched: cover property (!src[0] && str_ff[0] != '0);
  c_comm_timeout: cover property (|evt);
  c_reg_write: cover property (wr_pulse && req_ff.addr == MASK_ADDR);
endmodule : sdcm_cfg_bank

// ---- core/sdcm_pkg.sv ----
// Register map, field layout, reset values, timing and carrier types of the config bank
package sdcm_pkg;
  // Register offsets on the serial link
  localparam logic [3:0] LED_CFG_ADDR = 4'hD;
  localparam logic [3:0] WD_CFG_ADDR  = 4'hE;
  localparam logic [3:0] MASK_ADDR    = 4'hF;
  localparam logic [7:0] LED_CFG_RST  = 8'h53;
  localparam logic [7:0] WD_CFG_RST   = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'hBE;
  // led_and_filter_config fields
  localparam int B_LED_CLIM_MASK = 7;
  localparam int B_LATCH_EN      = 6;
  localparam int B_LONG_BLANK    = 5;
  localparam int B_FILT_EN       = 4;
  localparam int B_STRETCH_LO    = 2;
  localparam int B_STATUS_LED_MAN      = 1;
  localparam int B_FAULT_LED_MAN      = 0;
  // watchdog_and_threshold_config fields
  localparam int B_WD_LO         = 6;
  localparam int B_OWCUR_LO      = 4;
  localparam int B_SHTHR_LO      = 2;
  localparam int B_UPD_WD_EN     = 1;
  localparam int B_RESTART       = 0;
  // fault_output_mask fields
  localparam int B_COMM_M        = 7;
  localparam int B_SUP_M         = 6;
  localparam int B_GOOD_M        = 5;
  localparam int B_SHORT_M       = 4;
  localparam int B_OWON_M        = 3;
  localparam int B_OWOFF_M       = 2;
  localparam int B_CLIM_M        = 1;
  localparam int B_OVL_M         = 0;
  // Diagnostic classes; the last three are the filtered ones
  localparam int C_OVL   = 0;
  localparam int C_CLIM  = 1;
  localparam int C_OWOFF = 2;
  localparam int C_OWON  = 3;
  localparam int C_SHORT = 4;
  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int FILT_US         = 50;
  localparam int BLANK_SHORT_MS  = 4;
  localparam int BLANK_LONG_MS   = 8;
  localparam int STRETCH_STEP_MS = 1000;
  localparam int WD_SHORT_MS     = 200;
  localparam int WD_MID_MS       = 600;
  localparam int WD_LONG_MS      = 1200;
  localparam int BLANK_W         = 18;
  localparam int STR_W           = 27;
  localparam int WD_W            = 25;
  localparam int BLANK_SHORT_CYC = BLANK_SHORT_MS * (CLK_HZ / 1000);
  localparam int BLANK_LONG_CYC  = BLANK_LONG_MS * (CLK_HZ / 1000);
  localparam int STRETCH_CYC     = STRETCH_STEP_MS * (CLK_HZ / 1000);
  localparam int WD_SHORT_CYC    = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int WD_MID_CYC      = WD_MID_MS * (CLK_HZ / 1000);
  localparam int WD_LONG_CYC     = WD_LONG_MS * (CLK_HZ / 1000);
  localparam logic [BLANK_W-1:0] FILT_CNT = BLANK_W'(FILT_US * (CLK_HZ / 1_000_000));
  // Carriers
  typedef logic [4:0][7:0] sdcm_diag_type;
  typedef logic [2:0][7:0] sdcm_det_en_type;
  typedef struct packed {
    logic       tgl;
    logic [3:0] addr;
    logic [7:0] data;
  } sdcm_link_req_type;
  typedef struct packed {
    logic [7:0] led_cfg;
    logic [7:0] wd_cfg;
    logic [7:0] mask;
  } sdcm_regs_type;
  typedef struct packed {
    logic       fault_active;
    logic       global_irq_flag;
    logic       comm_error_irq_bit;
    logic       supply_error_irq_bit;
    logic       serial_supply_error_bit;
    logic       restart_high_thr;
    logic [1:0] open_wire_current_sel;
    logic [1:0] short_supply_threshold_sel;
    logic [7:0] fault_led;
    logic [7:0] status_led;
  } sdcm_out_type;
endpackage : sdcm_pkg

// ---- testbench/sdcm_host_model.sv ----
// Host serial master model driving the register link
`timescale 1ns/1ps
module sdcm_host_model (
  // Link toward the bank
  output logic       link_clk,
  output logic       link_wr,
  output logic [3:0] link_addr,
  output logic [7:0] link_wdata,
  input  wire logic  link_busy,
  input  wire logic [7:0] link_rdata
);
  logic run;
  int   late;
  initial begin
    late = 0;
    link_clk = 1'b0;
    run = 1'b0;
    link_wr = 1'b0;
    link_addr = 4'h0;
    link_wdata = 8'h00;
  end
  // Clock only within frames, parks low
  always begin
    #7.5;
    if (run || link_clk) link_clk = ~link_clk;
  end
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    int n;
    run = 1'b1;
    @(posedge link_clk);
    link_wr <= 1'b1;
    link_addr <= a;
    link_wdata <= d;
    @(posedge link_clk);
    link_wr <= 1'b0;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_busy !== 1'b0 && n < 60);
    if (link_busy !== 1'b0) late++;
    // Released data must not keep showing the written byte
    link_wdata <= ~d;
    run = 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    run = 1'b1;
    @(posedge link_clk);
    link_addr <= a;
    repeat (3) @(posedge link_clk);
    d = link_rdata;
    run = 1'b0;
  endtask : read_reg
endmodule : sdcm_host_model

// ---- testbench/sdcm_cfg_bank_bench.sv ----
// Self-checking bench of the config and mask register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sdcm_cfg_bank_bench;
  import sdcm_pkg::*;
  logic clk, sys_rst, link_clk, link_wr, link_busy, chain_pin, comm_clear;
  logic [3:0] link_addr;
  logic [7:0] link_wdata, link_rdata, rd, status_auto, status_led_set, fault_led_set;
  logic supply_not_good_flag, supply_warning_flag, supply_fail, update_pin;
  logic [4:0] flag_clear;
  logic crc_strap, a0_strap, a1_strap;
  sdcm_diag_type diag_raw, diag_flags;
  sdcm_det_en_type det_en;
  sdcm_out_type outs;
  int errors, checks;
  sdcm_cfg_bank #(.BLANK_SHORT_CYCLES(18'd1200), .BLANK_LONG_CYCLES(18'd2000),
    .STRETCH_CYCLES(27'd100), .WD_SHORT_CYCLES(25'd200), .WD_MID_CYCLES(25'd400),
    .WD_LONG_CYCLES(25'd600)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .link_wr(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata), .link_busy(link_busy),
    .link_rdata(link_rdata), .chain_pin(chain_pin), .crc_strap(crc_strap),
    .address0_watchdog_strap(a0_strap), .address1_update_watchdog_strap(a1_strap),
    .update_pin(update_pin), .diag_raw(diag_raw), .det_en(det_en),
    .flag_clear(flag_clear), .comm_clear(comm_clear),
    .supply_not_good_flag(supply_not_good_flag), .supply_warning_flag(supply_warning_flag),
    .supply_fail(supply_fail), .status_auto(status_auto), .status_led_set_register(status_led_set),
    .fault_led_set_register(fault_led_set), .diag_flags(diag_flags), .outs(outs));
  sdcm_host_model host_u (.link_clk(link_clk), .link_wr(link_wr), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_busy(link_busy), .link_rdata(link_rdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic close_out;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Whole run is well under a millisecond of bench time
  initial begin
    #3_000_000;
    errors++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    chain_pin = 1'b0;
    crc_strap = 1'b1;
    a0_strap = 1'b0;
    a1_strap = 1'b0;
    comm_clear = 1'b0;
    update_pin = 1'b0;
    supply_not_good_flag = 1'b0;
    supply_warning_flag = 1'b0;
    supply_fail = 1'b0;
    flag_clear = 5'h00;
    diag_raw = '0;
    det_en = {3{8'hFF}};
    status_auto = 8'h5A;
    status_led_set = 8'hC3;
    fault_led_set = 8'h3C;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    wt(3);
    host_u.read_reg(LED_CFG_ADDR, rd); `CHK(rd, LED_CFG_RST)
    host_u.read_reg(WD_CFG_ADDR, rd); `CHK(rd, WD_CFG_RST)
    host_u.read_reg(MASK_ADDR, rd); `CHK(rd, MASK_RST)
    host_u.write_reg(4'h3, 8'hA5);
    host_u.read_reg(4'h3, rd); `CHK(rd, 8'h00)
    `CHK(outs.status_led, 8'hC3)
    `CHK(outs.fault_led, 8'h3C)
    @(posedge clk) chain_pin <= 1'b1;
    wt(6);
    `CHK(outs.status_led, 8'h5A)
    `CHK(outs.restart_high_thr, 1'b1)
    @(posedge clk) chain_pin <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      host_u.write_reg(WD_CFG_ADDR, {2'b00, 2'(i), 2'(i), 1'b0, 1'(i)});
      wt(6);
      `CHK(outs.open_wire_current_sel, 2'(i))
      `CHK(outs.short_supply_threshold_sel, 2'(i))
      `CHK(outs.restart_high_thr, 1'(i))
      host_u.read_reg(WD_CFG_ADDR, rd); `CHK(rd, {2'b00, 2'(i), 2'(i), 1'b0, 1'(i)})
    end
    host_u.write_reg(LED_CFG_ADDR, 8'h50);
    @(posedge clk) diag_raw[C_OVL][0] <= 1'b1;
    wt(6);
    `CHK(outs.status_led, 8'h5A)
    `CHK(diag_flags[C_OVL][0], 1'b1)
    `CHK(outs.fault_active, 1'b1)
    `CHK(outs.fault_led[0], 1'b1)
    @(posedge clk) diag_raw[C_OVL][0] <= 1'b0;
    wt(6);
    `CHK(diag_flags[C_OVL][0], 1'b1)
    `CHK(outs.fault_led[0], 1'b0)
    @(posedge clk) flag_clear <= 5'h01;
    @(posedge clk) flag_clear <= 5'h00;
    wt(4);
    `CHK(diag_flags[C_OVL][0], 1'b0)
    host_u.write_reg(MASK_ADDR, 8'hBD);
    host_u.write_reg(LED_CFG_ADDR, 8'hD0);
    @(posedge clk) diag_raw[C_CLIM][1] <= 1'b1;
    wt(6);
    `CHK(outs.fault_active, 1'b1)
    `CHK(outs.fault_led[1], 1'b0)
    host_u.write_reg(MASK_ADDR, 8'hFF);
    wt(4);
    `CHK(outs.fault_active, 1'b0)
    `CHK(diag_flags[C_CLIM][1], 1'b1)
    host_u.write_reg(LED_CFG_ADDR, 8'h94);
    @(posedge clk) diag_raw[C_CLIM][1] <= 1'b0;
    wt(6);
    `CHK(diag_flags[C_CLIM][1], 1'b0)
    host_u.write_reg(MASK_ADDR, 8'hBE);
    @(posedge clk) diag_raw[C_OVL][2] <= 1'b1;
    wt(5);
    @(posedge clk) diag_raw[C_OVL][2] <= 1'b0;
    wt(50);
    `CHK(outs.fault_led[2], 1'b1)
    wt(80);
    `CHK(outs.fault_led[2], 1'b0)
    host_u.write_reg(LED_CFG_ADDR, 8'h00);
    @(posedge clk) diag_raw[C_OWOFF][0] <= 1'b1;
    wt(900);
    `CHK(diag_flags[C_OWOFF][0], 1'b0)
    wt(200);
    `CHK(diag_flags[C_OWOFF][0], 1'b1)
    `CHK(outs.fault_led[0], 1'b0)
    wt(200);
    `CHK(outs.fault_led[0], 1'b1)
    host_u.write_reg(LED_CFG_ADDR, 8'h30);
    @(posedge clk) diag_raw[C_OWOFF][0] <= 1'b0;
    @(posedge clk) diag_raw[C_OWON][4] <= 1'b1;
    wt(1500);
    `CHK(diag_flags[C_OWON][4], 1'b0)
    wt(600);
    `CHK(diag_flags[C_OWON][4], 1'b1)
    @(posedge clk) diag_raw[C_OWON][4] <= 1'b0;
    host_u.write_reg(WD_CFG_ADDR, 8'h40);
    wt(260);
    `CHK(outs.comm_error_irq_bit, 1'b1)
    `CHK(outs.global_irq_flag, 1'b1)
    `CHK(outs.fault_active, 1'b0)
    @(posedge clk) supply_not_good_flag <= 1'b1;
    wt(6);
    `CHK(outs.supply_error_irq_bit, 1'b0)
    @(posedge clk) supply_fail <= 1'b1;
    wt(6);
    `CHK(outs.supply_error_irq_bit, 1'b1)
    `CHK(outs.fault_active, 1'b1)
    host_u.write_reg(WD_CFG_ADDR, 8'h00);
    host_u.write_reg(MASK_ADDR, 8'h3E);
    @(posedge clk) comm_clear <= 1'b1;
    @(posedge clk) comm_clear <= 1'b0;
    wt(4);
    `CHK(outs.comm_error_irq_bit, 1'b0)
    @(posedge clk) begin
      chain_pin <= 1'b1;
      crc_strap <= 1'b0;
      a1_strap <= 1'b1;
    end
    wt(650);
    `CHK(outs.comm_error_irq_bit, 1'b0)
    `CHK(outs.fault_active, 1'b0)
    `CHK(outs.supply_error_irq_bit, 1'b0)
    `CHK(outs.serial_supply_error_bit, 1'b0)
    @(posedge clk) crc_strap <= 1'b1;
    wt(6);
    `CHK(outs.comm_error_irq_bit, 1'b1)
    `CHK(outs.serial_supply_error_bit, 1'b1)
    @(posedge clk) begin
      a1_strap <= 1'b0;
      a0_strap <= 1'b1;
      comm_clear <= 1'b1;
    end
    @(posedge clk) comm_clear <= 1'b0;
    wt(4);
    `CHK(outs.comm_error_irq_bit, 1'b0)
    wt(650);
    `CHK(outs.comm_error_irq_bit, 1'b1)
    `CHK(host_u.late, 0)
    close_out();
  end
endmodule : sdcm_cfg_bank_bench
